/* File: hdl/tesr_regs.sv */
// APB status register group: temperature, motion, queue and event source flags
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "tesr_consts.svh"

// Function
// - Temperature is 8-bit two's-complement reading
// - Code zero means 23 degrees Celsius
// - Each flag set when its engine triggers
// - Latch mode: permanent, timed or none
// - Disabled engines never raise their flags
// - Motion bits 7..4: flat, orient, taps
// - Motion bits 3..0: slow, slope, high, low
// - Queue bits 7..5: ready, threshold, full
// - Bit 7 of source: tap sign
// - Source bits 6..4: tap axes z,y,x
// - Bit 3 of source: slope sign
// - Source bits 2..0: slope axes z,y,x
module tesr_regs (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire tesr_pkg::tesr_apb_req_t apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Temperature sensor sample, offset from 23 C
  input  wire logic [7:0]            heat_code,
  // Engine trigger pulses and enables
  input  wire tesr_pkg::tesr_motion_t motion_trig,
  input  wire tesr_pkg::tesr_motion_t motion_en,
  input  wire tesr_pkg::tesr_queue_t  queue_trig,
  input  wire tesr_pkg::tesr_queue_t  queue_en,
  // Tap and slope source detail, valid with their trigger
  input  wire tesr_pkg::tesr_src_t    tap_src,
  input  wire tesr_pkg::tesr_src_t    slope_src,
  // Latch mode setting from the configuration block
  input  wire logic [3:0]            latch_mode
);
  import tesr_pkg::*;

  localparam int unsigned TEMP_CYC = `TESR_TEMP_LATCH_CYC;

  // Flag and detail state
  tesr_motion_t motion_q, motion_d;   // Motion flags
  tesr_queue_t  queue_q,  queue_d;    // Queue flags
  tesr_src_t    tap_q,    tap_d;      // Tap source detail
  tesr_src_t    slope_q,  slope_d;    // Slope source detail
  logic [7:0]   heat_q;               // Sampled temperature
  logic [15:0]  hold_q,   hold_d;     // Timed latch countdown

  // Qualified trigger pulses; a disabled engine cannot raise its flag
  wire tesr_motion_t m_hit = motion_trig & motion_en;
  wire tesr_queue_t  q_hit = queue_trig & queue_en;
  wire               any_hit = (|m_hit) | (|q_hit);

  // Latch mode decode
  wire perm_mode = (latch_mode == `TESR_LATCH_PERM) || (latch_mode == `TESR_LATCH_PERM_ALT);
  wire none_mode = (latch_mode == `TESR_LATCH_NONE);
  wire hold_done = (hold_q == 16'h0000);
  // Flags outside permanent mode drop when unlatched or the timer ran out
  wire drop_all  = !perm_mode && (none_mode || hold_done);

  // APB decode; reads are zero-wait, writes are accepted and ignored
  wire        acc     = apb_req.psel && apb_req.penable;
  wire [11:0] a       = apb_req.paddr;
  wire        hit_h   = (a == `TESR_ADDR(`TESR_IDX_HEAT));
  wire        hit_m   = (a == `TESR_ADDR(`TESR_IDX_MOTION));
  wire        hit_q   = (a == `TESR_ADDR(`TESR_IDX_QUEUE));
  wire        hit_s   = (a == `TESR_ADDR(`TESR_IDX_SOURCE));
  wire        mapped  = hit_h | hit_m | hit_q | hit_s;

  // Read data selection; queue reserved bits read zero
  wire [7:0] rd_byte = hit_h ? heat_q :
                       hit_m ? motion_q :
                       hit_q ? {queue_q, 5'h00} :
                       hit_s ? {tap_q, slope_q} :
                               `TESR_RST_BYTE;

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = {24'h000000, rd_byte};

  // Next flag state: a new event always wins over a drop
  always_comb begin
    motion_d = drop_all ? tesr_motion_t'(8'h00) : motion_q;
    queue_d  = drop_all ? tesr_queue_t'(3'h0) : queue_q;
    tap_d    = drop_all ? tesr_src_t'(4'h0) : tap_q;
    slope_d  = drop_all ? tesr_src_t'(4'h0) : slope_q;
    motion_d = motion_d | m_hit;
    queue_d  = queue_d | q_hit;
    if (m_hit.stap || m_hit.dtap) begin
      tap_d = tap_src;
    end
    if (m_hit.slope) begin
      slope_d = slope_src;
    end
    // Timer restarts on every event, otherwise counts down and holds at zero
    if (any_hit) begin
      hold_d = TEMP_CYC[15:0];
    end else if (!hold_done) begin
      hold_d = hold_q - 16'h0001;
    end else begin
      hold_d = hold_q;
    end
  end

  // Flag registers; bus writes never reach them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_q <= tesr_motion_t'(8'h00);
      queue_q  <= tesr_queue_t'(3'h0);
      tap_q    <= tesr_src_t'(4'h0);
      slope_q  <= tesr_src_t'(4'h0);
      hold_q   <= 16'h0000;
    end else begin
      motion_q <= motion_d;
      queue_q  <= queue_d;
      tap_q    <= tap_d;
      slope_q  <= slope_d;
      hold_q   <= hold_d;
    end
  end

  // Temperature follows the sensor every cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_q <= `TESR_RST_BYTE;
    end else begin
      heat_q <= heat_code;
    end
  end

  // Assertions
  sequence tap_evt_s;
    m_hit.stap || m_hit.dtap;
  endsequence

  flag_set_a : assert property (@(posedge pclk) disable iff (!presetn)
    (|m_hit) |=> ((motion_q & $past(m_hit)) == $past(m_hit)))
    else $error("motion flag not set by trigger");
  en_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
    (!$past(motion_en.low) && !$past(motion_q.low)) |-> !motion_q.low)
    else $error("disabled engine raised flag");
  perm_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
    (perm_mode && motion_q.flat) |=> motion_q.flat)
    else $error("permanent latch dropped flag");
  none_drop_a : assert property (@(posedge pclk) disable iff (!presetn)
    (none_mode && !(|m_hit)) |=> (motion_q == 8'h00))
    else $error("unlatched flag persisted");
  tap_src_a : assert property (@(posedge pclk) disable iff (!presetn)
    tap_evt_s |=> (tap_q == $past(tap_src)))
    else $error("tap detail not captured");
  slope_src_a : assert property (@(posedge pclk) disable iff (!presetn)
    m_hit.slope |=> (slope_q == $past(slope_src)))
    else $error("slope detail not captured");
  heat_read_a : assert property (@(posedge pclk) disable iff (!presetn)
    (acc && hit_h) |-> (prdata[7:0] == heat_q && prdata[31:8] == 24'h000000))
    else $error("temperature read mismatch");
  resv_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    (acc && hit_q) |-> (prdata[4:0] == 5'h00 && prdata[7] == queue_q.drdy))
    else $error("queue register layout wrong");
  write_ign_a : assert property (@(posedge pclk) disable iff (!presetn)
    (acc && apb_req.pwrite && !(|m_hit) && perm_mode) |=> (motion_q == $past(motion_q)))
    else $error("write altered status");
endmodule

/* File: hdl/tesr_consts.svh */
// Offsets, field positions, reset values and timing counts of the status register group
`ifndef TESR_CONSTS_SVH
`define TESR_CONSTS_SVH
// Offsets are all multiples of four, so they are register indices
`define TESR_IDX_HEAT        4'h8
`define TESR_IDX_MOTION      4'h9
`define TESR_IDX_QUEUE       4'ha
`define TESR_IDX_SOURCE      4'hb
// Byte address is four times the index
`define TESR_ADDR(idx)       {6'h00, idx, 2'h0}
// Motion flag positions
`define TESR_BIT_FLAT        7
`define TESR_BIT_ORIENT      6
`define TESR_BIT_STAP        5
`define TESR_BIT_DTAP        4
`define TESR_BIT_SLOW        3
`define TESR_BIT_SLOPE       2
`define TESR_BIT_HIGH        1
`define TESR_BIT_LOW         0
// Sample and queue flag positions
`define TESR_BIT_DRDY        7
`define TESR_BIT_QTHR        6
`define TESR_BIT_QFULL       5
// Event source fields
`define TESR_BIT_TAP_SIGN    7
`define TESR_BIT_SLOPE_SIGN  3
// Latch mode codes
`define TESR_LATCH_NONE      4'h0
`define TESR_LATCH_PERM      4'h7
`define TESR_LATCH_PERM_ALT  4'hf
// Temporary latch time and derived count
`define TESR_CLK_NS          50
`define TESR_TEMP_LATCH_NS   250000
`define TESR_TEMP_LATCH_CYC  (`TESR_TEMP_LATCH_NS / `TESR_CLK_NS)
// Reset values
`define TESR_RST_BYTE        8'h00
`endif

/* File: hdl/tesr_pkg.sv */
// Types shared by the status register group
package tesr_pkg;
  // Motion detection events, one bit per engine, msb first
  typedef struct packed {
    logic flat;
    logic orient;
    logic stap;
    logic dtap;
    logic slow;
    logic slope;
    logic high;
    logic low;
  } tesr_motion_t;
  // Sample and queue events
  typedef struct packed {
    logic drdy;
    logic qthr;
    logic qfull;
  } tesr_queue_t;
  // Sign and first axis of a tap or slope event
  typedef struct packed {
    logic sign;
    logic z;
    logic y;
    logic x;
  } tesr_src_t;
  // APB request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tesr_apb_req_t;
endpackage

/* File: tb/tesr_host.sv */
// Host model that reads and writes the status registers over APB
`timescale 1ns/100ps
module tesr_host (
  // Clock
  input  wire logic                pclk,
  // APB master side
  output tesr_pkg::tesr_apb_req_t  apb_req,
  input  wire logic [31:0]         prdata,
  input  wire logic                pready,
  input  wire logic                pslverr
);
  import tesr_pkg::*;
  logic [31:0] rdata; // Data taken at the last access
  logic        serr;  // Error taken at the last access
  initial apb_req = '0;
  // Setup, then access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk) apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    serr = pslverr;
    apb_req <= '0;
  endtask
endmodule

/* File: tb/test_temperature_and_event_status_regs.sv */
// Self-checking bench for the status register group
`timescale 1ns/100ps
`include "tesr_consts.svh"
module test_temperature_and_event_status_regs;
  import tesr_pkg::*;
  logic          pclk = 0;
  logic          presetn = 0;
  tesr_apb_req_t apb_req;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [7:0]    heat_code = 0;
  tesr_motion_t  mtrig = 0, men = 0;
  tesr_queue_t   qtrig = 0, qen = 0;
  tesr_src_t     tsrc = 0, ssrc = 0;
  logic [3:0]    latch_mode = 0;
  logic [63:0]   r;
  logic [7:0]    exp_m, exp_q, exp_s;
  integer        seed = 32'he07a90ae;
  integer        fails = 0;
  integer        check_count = 0;
  // None, permanent, permanent alias, timed; timed last for the expiry check
  logic [3:0]    modes [4] = '{4'h0, 4'h7, 4'hf, 4'h3};
  always #25 pclk = ~pclk;
  tesr_regs dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .heat_code(heat_code), .motion_trig(mtrig),
    .motion_en(men), .queue_trig(qtrig), .queue_en(qen), .tap_src(tsrc),
    .slope_src(ssrc), .latch_mode(latch_mode));
  tesr_host host (.pclk(pclk), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register read with expected low byte
  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    host.xfer(1'b0, `TESR_ADDR(idx), 32'h0);
    check(host.rdata, {24'h0, exp});
  endtask
  // Verdict, reached from the main sequence and the watchdog
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence: one random burst of events per latch mode
  initial begin
    for (int i = 0; i < 4; i++) begin
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      latch_mode <= modes[i];
      // Code zero, the 23 C point, is forced in the first pass; random afterwards
      heat_code <= (i == 0) ? 8'h00 : 8'($random(seed));
      r = {$random(seed), $random(seed)};
      @(posedge pclk);
      {mtrig, men, qtrig, qen, tsrc, ssrc} <= r[29:0];
      @(posedge pclk);
      exp_m = mtrig & men;
      exp_q = {qtrig & qen, 5'h00};
      exp_s = {(exp_m[5] | exp_m[4]) ? tsrc : 4'h0, exp_m[2] ? ssrc : 4'h0};
      mtrig <= '0;
      qtrig <= '0;
      // Unlatched flags are gone long before the read
      if (modes[i] == 4'h0) {exp_m, exp_q, exp_s} = 24'h000000;
      rd(`TESR_IDX_HEAT, heat_code);
      rd(`TESR_IDX_MOTION, exp_m);
      rd(`TESR_IDX_QUEUE, exp_q);
      rd(`TESR_IDX_SOURCE, exp_s);
      // Writes keep reserved bits at zero
      for (int a = 8; a < 12; a++) host.xfer(1'b1, `TESR_ADDR(a[3:0]), $random(seed) & 32'hffffffe0);
      rd(`TESR_IDX_MOTION, exp_m);
      rd(`TESR_IDX_SOURCE, exp_s);
      host.xfer(1'b0, 12'h030, 32'h0);
      check({31'h0, host.serr}, 32'h1);
      check(host.rdata, 32'h0);
    end
    // Timed latch must have expired
    repeat (5000) @(posedge pclk);
    rd(`TESR_IDX_MOTION, 8'h00);
    final_report();
  end
  // Watchdog well beyond the expected run
  initial begin
    #(50 * 20000);
    fails++;
    final_report();
  end
endmodule
